// >>> screen_layout_pkg.sv
// shared constants for the screen block layout register bank
package screen_layout_pkg;

   // register byte addresses on the host bus
   localparam logic [15:0] ADDR_FIRST_BASE_LOW   = 16'h800b;
   localparam logic [15:0] ADDR_FIRST_BASE_HIGH  = 16'h800c;
   localparam logic [15:0] ADDR_FIRST_LINES      = 16'h800d;
   localparam logic [15:0] ADDR_SECOND_BASE_LOW  = 16'h800e;
   localparam logic [15:0] ADDR_SECOND_BASE_HIGH = 16'h800f;
   localparam logic [15:0] ADDR_SECOND_LINES     = 16'h8010;
   localparam logic [15:0] ADDR_THIRD_BASE_LOW   = 16'h8011;
   localparam logic [15:0] ADDR_THIRD_BASE_HIGH  = 16'h8012;
   localparam logic [15:0] ADDR_FOURTH_BASE_LOW  = 16'h8013;
   localparam logic [15:0] ADDR_FOURTH_BASE_HIGH = 16'h8014;
   localparam logic [15:0] ADDR_CURSOR_WIDTH     = 16'h8015;
   localparam logic [15:0] ADDR_CURSOR_HEIGHT    = 16'h8016;

   // low byte address of each start address pair, block one first
   localparam logic [15:0] BASE_LOW_ADDR [4] = '{
      16'h800b, 16'h800e, 16'h8011, 16'h8013};

   // reset values and field layout
   localparam logic [7:0]  RESET_BYTE        = 8'h00;
   localparam logic [15:0] RESET_BASE        = 16'h0000;
   localparam logic [3:0]  RESET_NIBBLE      = 4'h0;
   localparam int          CURSOR_WIDTH_MSB  = 3;

   // indirect command codes (values arbitrary)
   localparam logic [7:0]  CMD_SCROLL        = 8'h01;
   localparam logic [7:0]  CMD_CURSOR_SHAPE  = 8'h02;

   // parameter bytes taken by each indirect command
   localparam logic [3:0]  SCROLL_PARAM_COUNT = 4'ha;
   localparam logic [3:0]  CURSOR_PARAM_COUNT = 4'h2;
   localparam logic [3:0]  RESET_PARAM_INDEX  = 4'h0;

   // indirect parameter sequencer states, gray along the path
   typedef enum logic [1:0] {
      PARAM_IDLE   = 2'b00,
      PARAM_SCROLL = 2'b01,
      PARAM_CURSOR = 2'b11
   } param_state_t;

endpackage

// >>> base_pair_if.sv
// carrier between the register bank and one start address pair
`timescale 1ns/1ps
interface base_pair_if;
   logic        wr_low;
   logic        wr_high;
   logic [7:0]  wdata;
   logic [7:0]  pending_low;
   logic [15:0] active;

   modport ctrl (output wr_low, output wr_high, output wdata,
                 input pending_low, input active);
   modport pair (input wr_low, input wr_high, input wdata,
                 output pending_low, output active);
endinterface

// >>> base_pair.sv
// one 16-bit start address with a pending low byte
`timescale 1ns/1ps
module base_pair
   import screen_layout_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  reset,
   base_pair_if.pair  p
);

   logic [7:0]  pending_low_q;
   logic [15:0] active_q;

   // low byte parks here so the scanner never sees a half-updated address
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pending_low_q <= RESET_BYTE;
      end else if (p.wr_low) begin
         pending_low_q <= p.wdata;
      end
   end

   // high byte write commits both halves in one edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         active_q <= RESET_BASE;
      end else if (p.wr_high) begin
         active_q <= {p.wdata, pending_low_q};
      end
   end

   assign p.pending_low = pending_low_q;
   assign p.active      = active_q;

endmodule // base_pair

// >>> screen_block_layout_regs.sv
// screen block layout register bank with direct and indirect access
`timescale 1ns/1ps
module screen_block_layout_regs
   import screen_layout_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   // direct register access
   input  wire logic [15:0] addr,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata,
   output logic             rd_valid,
   // indirect command access
   input  wire logic        cmd_wr,
   input  wire logic        param_wr,
   // frame setup from elsewhere in the controller
   input  wire logic [7:0]  lines_per_frame,
   input  wire logic        dual_panel,
   // cursor height is kept outside; this bank forwards its parameter
   input  wire logic [7:0]  cursor_height_value,
   output logic             cursor_height_load,
   output logic      [7:0]  cursor_height_data,
   // values for the frame scanner
   output logic      [15:0] first_block_base,
   output logic      [15:0] second_block_base,
   output logic      [15:0] third_block_base,
   output logic      [15:0] fourth_block_base,
   output logic      [7:0]  first_block_lines,
   output logic      [7:0]  second_block_lines,
   output logic      [7:0]  third_block_lines,
   output logic      [7:0]  fourth_block_lines,
   output logic      [8:0]  first_block_blank,
   output logic      [8:0]  second_block_blank,
   output logic      [3:0]  cursor_horizontal_extent
);

   // low byte address to pair index; bit 2 flags a match
   function automatic logic [2:0] low_slot(input logic [15:0] a);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (a == BASE_LOW_ADDR[i]) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction

   // high byte address sits one above the low byte in every pair
   function automatic logic [2:0] high_slot(input logic [15:0] a);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (a == BASE_LOW_ADDR[i] + 16'h0001) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction

   param_state_t state_q;
   logic [3:0]   param_index_q;
   logic [7:0]   first_lines_q;
   logic [7:0]   second_lines_q;
   logic [3:0]   cursor_width_q;
   logic         height_load_q;
   logic [7:0]   height_data_q;
   logic [7:0]   rdata_q;
   logic         rd_valid_q;
   logic [7:0]   third_lines_q;
   logic [7:0]   fourth_lines_q;
   logic [8:0]   blank_one_q;
   logic [8:0]   blank_two_q;

   logic         wr_go;
   logic [15:0]  wr_addr;
   logic [2:0]   wr_low_slot;
   logic [2:0]   wr_high_slot;
   logic [2:0]   rd_low_slot;
   logic [2:0]   rd_high_slot;
   logic [8:0]   half_frame;
   logic [8:0]   lines_one;
   logic [8:0]   lines_two;

   base_pair_if pairs[4] ();

   // one pending-then-commit pair per screen block
   for (genvar g = 0; g < 4; g++) begin : g_pair
      assign pairs[g].wr_low  = wr_go && wr_low_slot[2]
                                && (wr_low_slot[1:0] == 2'(g));
      assign pairs[g].wr_high = wr_go && wr_high_slot[2]
                                && (wr_high_slot[1:0] == 2'(g));
      assign pairs[g].wdata   = wdata;
      base_pair u_pair (
         .clk   (clk),
         .reset (reset),
         .p     (pairs[g])
      );
   end

   // a direct write wins; a parameter byte maps onto the next register
   always_comb begin
      wr_go   = wr_en;
      wr_addr = addr;
      if (!wr_en && param_wr) begin
         unique case (state_q)
            PARAM_SCROLL: begin
               wr_go   = param_index_q < SCROLL_PARAM_COUNT;
               wr_addr = ADDR_FIRST_BASE_LOW + {12'h000, param_index_q};
            end
            PARAM_CURSOR: begin
               wr_go   = param_index_q < CURSOR_PARAM_COUNT;
               wr_addr = ADDR_CURSOR_WIDTH + {12'h000, param_index_q};
            end
            PARAM_IDLE: begin
               wr_go   = 1'b0;
               wr_addr = addr;
            end
            default: begin
               wr_go   = 1'b0;
               wr_addr = addr;
            end
         endcase
      end
   end

   assign wr_low_slot  = low_slot(wr_addr);
   assign wr_high_slot = high_slot(wr_addr);
   assign rd_low_slot  = low_slot(addr);
   assign rd_high_slot = high_slot(addr);

   // command byte picks the parameter target; unknown codes end the sequence
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= PARAM_IDLE;
      end else if (cmd_wr) begin
         if (wdata == CMD_CURSOR_SHAPE) begin
            state_q <= PARAM_CURSOR;
         end else if (wdata == CMD_SCROLL) begin
            state_q <= PARAM_SCROLL;
         end else begin
            state_q <= PARAM_IDLE;
         end
      end
   end

   // parameter counter saturates so extra bytes are dropped
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         param_index_q <= RESET_PARAM_INDEX;
      end else if (cmd_wr) begin
         param_index_q <= RESET_PARAM_INDEX;
      end else if (param_wr && !wr_en && state_q != PARAM_IDLE
                   && param_index_q != 4'hf) begin
         param_index_q <= param_index_q + 4'h1;
      end
   end

   // line count registers hold lines minus one
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         first_lines_q  <= RESET_BYTE;
         second_lines_q <= RESET_BYTE;
      end else if (wr_go) begin
         if (wr_addr == ADDR_FIRST_LINES) begin
            first_lines_q <= wdata;
         end
         if (wr_addr == ADDR_SECOND_LINES) begin
            second_lines_q <= wdata;
         end
      end
   end

   // only the low nibble of the width is stored; the rest reads zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cursor_width_q <= RESET_NIBBLE;
      end else if (wr_go && wr_addr == ADDR_CURSOR_WIDTH) begin
         cursor_width_q <= wdata[CURSOR_WIDTH_MSB:0];
      end
   end

   // height byte goes on to the cursor height register as a pulse
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         height_load_q <= 1'b0;
         height_data_q <= RESET_BYTE;
      end else begin
         height_load_q <= wr_go && wr_addr == ADDR_CURSOR_HEIGHT;
         if (wr_go && wr_addr == ADDR_CURSOR_HEIGHT) begin
            height_data_q <= wdata;
         end
      end
   end

   // half the frame height, rounded down, in lines
   assign half_frame = ({1'b0, lines_per_frame} + 9'h001) >> 1;
   assign lines_one  = {1'b0, first_lines_q} + 9'h001;
   assign lines_two  = {1'b0, second_lines_q} + 9'h001;

   // derived block heights, registered to keep the compare off the scan path
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         third_lines_q  <= RESET_BYTE;
         fourth_lines_q <= RESET_BYTE;
      end else begin
         third_lines_q <= (first_lines_q < second_lines_q)
                          ? first_lines_q : second_lines_q;
         if (dual_panel) begin
            fourth_lines_q <= 8'(half_frame - 9'h001);
         end else begin
            fourth_lines_q <= lines_per_frame;
         end
      end
   end

   // lines short of half a frame are blanked only with a dual panel
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         blank_one_q <= 9'h000;
         blank_two_q <= 9'h000;
      end else begin
         blank_one_q <= (dual_panel && half_frame > lines_one)
                        ? half_frame - lines_one : 9'h000;
         blank_two_q <= (dual_panel && half_frame > lines_two)
                        ? half_frame - lines_two : 9'h000;
      end
   end

   // read data one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_q    <= RESET_BYTE;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_en;
         if (rd_en) begin
            if (rd_low_slot[2]) begin
               rdata_q <= pairs_low(rd_low_slot[1:0]);
            end else if (rd_high_slot[2]) begin
               rdata_q <= pairs_high(rd_high_slot[1:0]);
            end else if (addr == ADDR_FIRST_LINES) begin
               rdata_q <= first_lines_q;
            end else if (addr == ADDR_SECOND_LINES) begin
               rdata_q <= second_lines_q;
            end else if (addr == ADDR_CURSOR_WIDTH) begin
               rdata_q <= {4'h0, cursor_width_q};
            end else if (addr == ADDR_CURSOR_HEIGHT) begin
               rdata_q <= cursor_height_value;
            end else begin
               rdata_q <= RESET_BYTE;
            end
         end
      end
   end

   // interface arrays need constant indices, so flatten them once
   logic [7:0]  low_bytes  [4];
   logic [7:0]  high_bytes [4];
   logic [15:0] bases      [4];
   for (genvar g = 0; g < 4; g++) begin : g_flat
      assign low_bytes[g]  = pairs[g].pending_low;
      assign high_bytes[g] = pairs[g].active[15:8];
      assign bases[g]      = pairs[g].active;
   end

   function automatic logic [7:0] pairs_low(input logic [1:0] i);
      return low_bytes[i];
   endfunction

   function automatic logic [7:0] pairs_high(input logic [1:0] i);
      return high_bytes[i];
   endfunction

   // outputs
   assign rdata                    = rdata_q;
   assign rd_valid                 = rd_valid_q;
   assign cursor_height_load       = height_load_q;
   assign cursor_height_data       = height_data_q;
   assign first_block_base         = bases[0];
   assign second_block_base        = bases[1];
   assign third_block_base         = bases[2];
   assign fourth_block_base        = bases[3];
   assign first_block_lines        = first_lines_q;
   assign second_block_lines       = second_lines_q;
   assign third_block_lines        = third_lines_q;
   assign fourth_block_lines       = fourth_lines_q;
   assign first_block_blank        = blank_one_q;
   assign second_block_blank       = blank_two_q;
   assign cursor_horizontal_extent = cursor_width_q;

endmodule // screen_block_layout_regs

// >>> screen_layout_sva.sv
// assertions on the ports of the screen block layout register bank
`timescale 1ns/1ps
module screen_layout_sva
   import screen_layout_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [15:0] addr,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [7:0]  wdata,
   input wire logic        rd_valid,
   input wire logic [7:0]  lines_per_frame,
   input wire logic        dual_panel,
   input wire logic [15:0] second_block_base,
   input wire logic [7:0]  first_block_lines,
   input wire logic [7:0]  second_block_lines,
   input wire logic [7:0]  third_block_lines,
   input wire logic [7:0]  fourth_block_lines,
   input wire logic [8:0]  first_block_blank,
   input wire logic [3:0]  cursor_horizontal_extent
);
   logic [8:0] half_q;
   logic [7:0] lpf_q, sl1_q, sl2_q;
   logic       dual_q;

   // previous-cycle copies, since derived outputs lag their sources by one edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         half_q <= 9'h000;
         lpf_q  <= 8'h00;
         sl1_q  <= 8'h00;
         sl2_q  <= 8'h00;
         dual_q <= 1'b0;
      end else begin
         half_q <= ({1'b0, lines_per_frame} + 9'h001) >> 1;
         lpf_q  <= lines_per_frame;
         sl1_q  <= first_block_lines;
         sl2_q  <= second_block_lines;
         dual_q <= dual_panel;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   read_answer_a: assert property (rd_en |=> rd_valid)
      else $error("read request got no answer");
   read_quiet_a: assert property (!rd_en |=> !rd_valid)
      else $error("answer without read request");
   low_hold_a: assert property ((wr_en && addr == ADDR_SECOND_BASE_LOW) |=> $stable(second_block_base))
      else $error("low byte write moved the active address");
   high_commit_a: assert property ((wr_en && addr == ADDR_SECOND_BASE_HIGH)
      |=> second_block_base[15:8] == $past(wdata))
      else $error("high byte write did not commit");
   first_lines_a: assert property ((wr_en && addr == ADDR_FIRST_LINES)
      |=> first_block_lines == $past(wdata))
      else $error("block one line count not loaded");
   third_min_a: assert property (third_block_lines == (sl1_q < sl2_q ? sl1_q : sl2_q))
      else $error("block three lines not the smaller count");
   fourth_lines_a: assert property (fourth_block_lines == (dual_q ? 8'(half_q - 9'h001) : lpf_q))
      else $error("block four lines wrong");
   first_blank_a: assert property (first_block_blank == ((dual_q && half_q > {1'b0, sl1_q} + 9'h001)
      ? half_q - {1'b0, sl1_q} - 9'h001 : 9'h000))
      else $error("block one blank count wrong");
   cursor_width_a: assert property ((wr_en && addr == ADDR_CURSOR_WIDTH)
      |=> {4'h0, cursor_horizontal_extent} == ($past(wdata) & 8'h0f))
      else $error("cursor width not loaded");
endmodule // screen_layout_sva

// >>> host_model.sv
// host processor model driving the register and indirect command bus
`timescale 1ns/1ps
module host_model
   import screen_layout_pkg::*;
(
   input  wire logic        clk,
   output logic      [15:0] addr,
   output logic             wr_en,
   output logic             rd_en,
   output logic      [7:0]  wdata,
   output logic             cmd_wr,
   output logic             param_wr
);
   initial begin
      addr = 16'h0000;
      wdata = 8'h00;
      {wr_en, rd_en, cmd_wr, param_wr} = 4'h0;
   end

   // one strobe per call; released data is inverted so it never lingers
   task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic [3:0] kind);
      @(negedge clk);
      addr = a;
      wdata = d;
      {wr_en, rd_en, cmd_wr, param_wr} = kind;
      @(negedge clk);
      {wr_en, rd_en, cmd_wr, param_wr} = 4'h0;
      wdata = ~wdata;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      cycle(a, d, 4'h8);
   endtask
   task automatic rd(input logic [15:0] a);
      cycle(a, ~wdata, 4'h4);
   endtask
   task automatic cmd(input logic [7:0] c);
      cycle(addr, c, 4'h2);
   endtask
   task automatic prm(input logic [7:0] d);
      cycle(addr, d, 4'h1);
   endtask
   // start address always low byte ahead of high byte
   task automatic wbase(input int blk, input logic [15:0] v);
      wr(BASE_LOW_ADDR[blk], v[7:0]);
      wr(BASE_LOW_ADDR[blk] + 16'h0001, v[15:8]);
   endtask
endmodule // host_model

// >>> testbench.sv
// self-checking bench for the screen block layout register bank
`timescale 1ns/1ps
module testbench
   import screen_layout_pkg::*;
;
   localparam int CHAR_COLS = 8; // horizontal character size the host assumes
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [15:0] addr, base [4];
   logic        wr_en, rd_en, cmd_wr, param_wr, rd_valid, dual_panel, cursor_height_load;
   logic [7:0]  wdata, rdata, lines_per_frame, cursor_height_value, cursor_height_data;
   logic [7:0]  lines [4];
   logic [8:0]  blank1, blank2;
   logic [3:0]  cursor_horizontal_extent;
   logic [7:0]  rq [$], hq [$];
   int          failures = 0, checked = 0;

   always #2.5 clk = ~clk;

   host_model host_model_inst (.clk, .addr, .wr_en, .rd_en, .wdata, .cmd_wr, .param_wr);
   screen_block_layout_regs screen_block_layout_regs_inst (.clk, .reset, .addr, .wr_en, .rd_en,
      .wdata, .rdata, .rd_valid, .cmd_wr, .param_wr, .lines_per_frame, .dual_panel,
      .cursor_height_value, .cursor_height_load, .cursor_height_data,
      .first_block_base(base[0]), .second_block_base(base[1]), .third_block_base(base[2]),
      .fourth_block_base(base[3]), .first_block_lines(lines[0]), .second_block_lines(lines[1]),
      .third_block_lines(lines[2]), .fourth_block_lines(lines[3]),
      .first_block_blank(blank1), .second_block_blank(blank2), .cursor_horizontal_extent);

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // note the expected byte, then issue the read
   task automatic rdx(input logic [15:0] a, input logic [7:0] e);
      rq.push_back(e);
      host_model_inst.rd(a);
   endtask

   // results are taken off mid-cycle, where registered outputs have settled
   always @(negedge clk) begin
      if (rd_valid === 1'b1) begin
         if (rq.size() == 0) failures++;
         else check(rdata, rq.pop_front());
      end
      if (cursor_height_load === 1'b1) begin
         if (hq.size() == 0) failures++;
         else check(cursor_height_data, hq.pop_front());
      end
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude();
   end

   initial begin
      int i, seed_sink;
      logic [15:0] v;
      logic [7:0] a, b, n, h, w;
      logic [8:0] half;
      logic [7:0] p [10];
      lines_per_frame = 8'h01;
      dual_panel = 1'b0;
      cursor_height_value = 8'h00;
      seed_sink = $urandom(2);
      repeat (8) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      cursor_height_value = 8'($urandom);
      // reset values, last one the outside cursor height, then an unmapped byte
      for (i = 0; i < 12; i++) rdx(16'h800b + 16'(i), i == 11 ? cursor_height_value : 8'h00);
      rdx(16'h8017, 8'h00);
      // each block: full pair, lone low byte, lone high byte
      for (i = 0; i < 4; i++) begin
         v = 16'($urandom);
         n = 8'($urandom);
         h = 8'($urandom);
         host_model_inst.wbase(i, v);
         check(base[i], v);
         host_model_inst.wr(BASE_LOW_ADDR[i], n);
         check(base[i], v);
         rdx(BASE_LOW_ADDR[i], n);
         host_model_inst.wr(BASE_LOW_ADDR[i] + 16'h0001, h);
         check(base[i], {h, n});
         rdx(BASE_LOW_ADDR[i] + 16'h0001, h);
      end
      // plain, dual panel, then plain again with both counts at frame plus one
      for (i = 0; i < 3; i++) begin
         dual_panel = (i == 1);
         lines_per_frame = 8'($urandom_range(254, 1));
         a = (i == 2) ? lines_per_frame + 8'h01 : 8'($urandom);
         b = (i == 2) ? a : 8'($urandom_range(127, 0));
         host_model_inst.wr(ADDR_FIRST_LINES, a);
         host_model_inst.wr(ADDR_SECOND_LINES, b);
         @(negedge clk);
         half = ({1'b0, lines_per_frame} + 9'h001) >> 1;
         check(lines[2], a < b ? a : b);
         check(lines[3], dual_panel ? 8'(half - 9'h001) : lines_per_frame);
         check(blank1, dual_panel && half > a + 9'h1 ? half - a - 9'h1 : 9'h0);
         check(blank2, dual_panel && half > b + 9'h1 ? half - b - 9'h1 : 9'h0);
         rdx(ADDR_FIRST_LINES, a);
         rdx(ADDR_SECOND_LINES, b);
      end
      // cursor width keeps only its low nibble
      host_model_inst.wr(ADDR_CURSOR_WIDTH, 8'hff);
      rdx(ADDR_CURSOR_WIDTH, 8'h0f);
      hq.push_back(8'h5a);
      host_model_inst.wr(ADDR_CURSOR_HEIGHT, 8'h5a);
      // cursor shape command, width kept inside the character cell
      repeat (3) begin
         w = 8'($urandom_range(CHAR_COLS - 1, 0));
         h = 8'($urandom);
         hq.push_back(h);
         host_model_inst.cmd(CMD_CURSOR_SHAPE);
         host_model_inst.prm(w);
         check(cursor_horizontal_extent, w);
         host_model_inst.prm(h);
      end
      // scroll command loads all ten bytes in address order
      host_model_inst.cmd(CMD_SCROLL);
      for (i = 0; i < 10; i++) begin
         p[i] = 8'($urandom);
         host_model_inst.prm(p[i]);
      end
      check(base[0], {p[1], p[0]});
      check(lines[0], p[2]);
      check(base[1], {p[4], p[3]});
      check(lines[1], p[5]);
      check(base[2], {p[7], p[6]});
      check(base[3], {p[9], p[8]});
      // an eleventh byte is dropped instead of landing on the cursor width
      host_model_inst.prm({4'h0, ~w[3:0]});
      check(cursor_horizontal_extent, w);
      // an unknown command leaves its parameters unused
      host_model_inst.cmd(8'h00);
      for (i = 0; i < 3; i++) host_model_inst.prm(~p[i]);
      check(lines[0], p[2]);
      for (i = 0; i < 10 && rq.size() + hq.size() > 0; i++) @(posedge clk);
      if (rq.size() + hq.size() > 0) failures++;
      conclude();
   end
endmodule // testbench

bind screen_block_layout_regs screen_layout_sva screen_layout_sva_inst (.clk, .reset, .addr,
   .wr_en, .rd_en, .wdata, .rd_valid, .lines_per_frame, .dual_panel, .second_block_base,
   .first_block_lines, .second_block_lines, .third_block_lines, .fourth_block_lines,
   .first_block_blank, .cursor_horizontal_extent);
